// file: start_stop_pkg.sv
// shared constants, encodings and register map for the test start/stop control block
// assumes a 40 MHz clock and a 32-bit axi4-lite register bus
package start_stop_pkg;

  // clock and contact timing
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned CONTACT_MIN_US  = 1000;
  // least time in whole cycles; the fractional megahertz part of the clock is truncated, not rounded up
  localparam int unsigned CONTACT_CYCLES  = (CONTACT_MIN_US * (CLK_HZ / 1000000) + 0) ;
  localparam int unsigned CNT_W           = 16;

  // baud divisors, cycles per bit at 40 MHz
  localparam logic [15:0] BAUD_9600_DIV   = 16'(CLK_HZ / 9600);
  localparam logic [15:0] BAUD_19200_DIV  = 16'(CLK_HZ / 19200);
  localparam logic [15:0] BAUD_38400_DIV  = 16'(CLK_HZ / 38400);
  localparam logic [15:0] BAUD_57600_DIV  = 16'(CLK_HZ / 57600);
  localparam logic [15:0] BAUD_115200_DIV = 16'(CLK_HZ / 115200);

  // start source codes
  localparam logic [1:0] SRC_FRONT  = 2'h0;
  localparam logic [1:0] SRC_REMOTE = 2'h1;
  localparam logic [1:0] SRC_SIGNAL = 2'h2;

  // remote interface codes
  localparam logic [1:0] IF_USB    = 2'h0;
  localparam logic [1:0] IF_SERIAL = 2'h1;
  localparam logic [1:0] IF_GPIB   = 2'h2;

  // baud select codes
  localparam logic [2:0] BAUD_9600   = 3'h0;
  localparam logic [2:0] BAUD_19200  = 3'h1;
  localparam logic [2:0] BAUD_38400  = 3'h2;
  localparam logic [2:0] BAUD_57600  = 3'h3;
  localparam logic [2:0] BAUD_115200 = 3'h4;

  localparam logic [4:0] GPIB_ADDR_MAX = 5'h1e;
  localparam logic [7:0] LINE_FEED     = 8'h0a;
  localparam logic [7:0] COMMA_CHAR    = 8'h2c;
  localparam int unsigned SERIAL_LEN   = 12;
  localparam int unsigned ID_LEN       = 32;

  // register byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_IFACE  = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0c;
  localparam logic [7:0] REG_ID     = 8'h10;

  // control, interface and result register fields and reset values
  localparam int unsigned CTRL_SRC_LSB  = 0;
  localparam int unsigned CTRL_ILK_BIT  = 2;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam int unsigned IF_SEL_LSB    = 0;
  localparam int unsigned IF_BAUD_LSB   = 4;
  localparam int unsigned IF_ADDR_LSB   = 8;
  localparam logic [31:0] IFACE_RESET   = 32'h0000_0041;
  localparam int unsigned RES_PASS_BIT  = 0;
  localparam int unsigned RES_FAIL_BIT  = 1;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // panel states, one-hot
  typedef enum logic [3:0] {
    ST_VIEW   = 4'b0001,
    ST_READY  = 4'b0010,
    ST_TEST   = 4'b0100,
    ST_REMOTE = 4'b1000
  } panel_state_t;

endpackage

// file: test_start_stop_control.sv
// start/stop, interlock, status outputs and remote interface selection of a test instrument
// assumes synchronous debounced contact inputs (high = closed to common) and an axi4-lite master
`timescale 1ns/1ps
module test_start_stop_control
  import start_stop_pkg::*;
#(
  parameter logic [31:0] MODEL_CODE = 32'h0000_0001,  // arbitrary model code
  parameter logic [31:0] FW_CODE    = 32'h0000_0001   // arbitrary firmware code
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  // rear signal port, high means contact closed to input common
  input  wire logic        start_contact,
  input  wire logic        stop_contact,
  input  wire logic        loop_in_a,
  input  wire logic        loop_in_b,
  output logic             test_out,
  output logic             fail_out,
  output logic             pass_out,
  // front panel and remote controller keys, one-cycle pulses
  input  wire logic        start_key,
  input  wire logic        stop_key,
  input  wire logic        manual_auto_key,
  input  wire logic        remote_start,
  // measurement result, one-cycle pulses while testing
  input  wire logic        test_done_pass,
  input  wire logic        test_done_fail,
  // remote command stream, one byte per strobe
  input  wire logic        cmd_byte_valid,
  input  wire logic [7:0]  cmd_byte,
  input  wire logic        gpib_listen,
  input  wire logic [4:0]  gpib_bus_addr,
  output logic             cmd_line_done,
  output logic             remote_indicator,
  output logic             keys_enabled,
  output logic             interlock_open_msg,
  output logic             usb_active,
  output logic             serial_active,
  output logic             gpib_active,
  output logic [15:0]      baud_div,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // address decode shared by read and write paths
  function automatic logic addr_mapped(input logic [7:0] a, input logic wr);
    addr_mapped = (a == REG_CTRL) || (a == REG_IFACE) ||
                  (!wr && ((a == REG_STATUS) || (a == REG_RESULT) || (a == REG_ID)));
  endfunction

  // byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  logic [31:0]      ctrl_reg;       // start source, interlock enable
  logic [31:0]      iface_reg;      // interface, baud, gpib address
  logic [7:0]       aw_addr_reg;    // captured write address
  logic             aw_held_reg;
  logic [31:0]      w_data_reg;     // captured write data
  logic [3:0]       w_strb_reg;
  logic             w_held_reg;
  panel_state_t     state_reg;      // panel state
  logic [CNT_W-1:0] stop_cnt_reg;   // stop closure length
  logic [CNT_W-1:0] start_cnt_reg;  // start closure length
  logic             stop_seen_reg;  // stop held past minimum, awaiting release
  logic             start_seen_reg;
  logic             pass_reg;
  logic             fail_reg;
  logic             ilk_msg_reg;
  logic             line_done_reg;
  logic [SERIAL_LEN*8-1:0] serial_reg;  // serial number text, set over the id register
  logic [31:0] iface_wr;  // interface register as a pending write would leave it
  logic [1:0]  src;
  logic        ilk_en;
  logic [1:0]  if_sel;
  logic [2:0]  baud_sel;
  logic [4:0]  gpib_addr;
  logic        loop_closed;
  logic        start_ok;
  logic        sig_stop_ev;
  logic        sig_start_ev;
  logic        start_req;
  logic        stop_req;
  logic        cmd_ev;
  logic        wr_fire;
  assign src         = ctrl_reg[CTRL_SRC_LSB +: 2];
  assign ilk_en      = ctrl_reg[CTRL_ILK_BIT];
  assign if_sel      = iface_reg[IF_SEL_LSB +: 2];
  assign baud_sel    = iface_reg[IF_BAUD_LSB +: 3];
  assign gpib_addr   = iface_reg[IF_ADDR_LSB +: 5];
  assign loop_closed = loop_in_a & loop_in_b;
  assign iface_wr    = merge(iface_reg, w_data_reg, w_strb_reg);
  assign start_ok = !ilk_en || loop_closed;
  assign sig_stop_ev  = (src == SRC_SIGNAL) && stop_contact &&
                        (stop_cnt_reg == CNT_W'(CONTACT_CYCLES - 1)) && !stop_seen_reg;
  assign sig_start_ev = (src == SRC_SIGNAL) && start_contact &&
                        (start_cnt_reg == CNT_W'(CONTACT_CYCLES - 1)) && !start_seen_reg;
  // three start sources select the start request
  always_comb begin
    unique case (src)
      SRC_FRONT:  start_req = start_key;
      SRC_REMOTE: start_req = remote_start;
      SRC_SIGNAL: start_req = sig_start_ev;
      default:    start_req = 1'b0;
    endcase
  end

  assign stop_req = stop_key || sig_stop_ev;
  // usb uses the serial byte path
  always_comb begin
    cmd_ev = 1'b0;
    if (cmd_byte_valid && (cmd_byte == LINE_FEED)) begin
      cmd_ev = (if_sel == IF_USB) || (if_sel == IF_SERIAL) ||
               ((if_sel == IF_GPIB) && gpib_listen && (gpib_bus_addr == gpib_addr));
    end
  end
  assign usb_active    = (if_sel == IF_USB);
  assign serial_active = (if_sel == IF_SERIAL);
  assign gpib_active   = (if_sel == IF_GPIB);

  // baud divisor per selection; unknown codes fall back to the slowest rate
  always_comb begin
    if (if_sel == IF_USB) begin
      baud_div = BAUD_115200_DIV;
    end else begin
      unique case (baud_sel)
        BAUD_19200:  baud_div = BAUD_19200_DIV;
        BAUD_38400:  baud_div = BAUD_38400_DIV;
        BAUD_57600:  baud_div = BAUD_57600_DIV;
        BAUD_115200: baud_div = BAUD_115200_DIV;
        default:     baud_div = BAUD_9600_DIV;
      endcase
    end
  end

  // contact closure timers; a closure counts once until released
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stop_cnt_reg   <= '0;
      start_cnt_reg  <= '0;
      stop_seen_reg  <= 1'b0;
      start_seen_reg <= 1'b0;
    end else if (clk_en) begin
      if (!stop_contact) begin
        stop_cnt_reg  <= '0;
        stop_seen_reg <= 1'b0;
      end else if (stop_cnt_reg == CNT_W'(CONTACT_CYCLES - 1)) begin
        stop_seen_reg <= 1'b1;
      end else begin
        stop_cnt_reg <= stop_cnt_reg + 1'b1;
      end
      if (!start_contact) begin
        start_cnt_reg  <= '0;
        start_seen_reg <= 1'b0;
      end else if (start_cnt_reg == CNT_W'(CONTACT_CYCLES - 1)) begin
        start_seen_reg <= 1'b1;
      end else begin
        start_cnt_reg <= start_cnt_reg + 1'b1;
      end
    end
  end

  // panel state machine; stop is ignored in ready so start wins there, remote commands outrank keys in view and ready
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_VIEW;
    end else if (clk_en) begin
      unique case (state_reg)
        ST_REMOTE: begin
          if (stop_req) begin
            state_reg <= ST_READY;
          end
        end
        ST_TEST: begin
          if (stop_req || test_done_pass || test_done_fail) begin
            state_reg <= ST_READY;
          end
        end
        ST_READY: begin
          if (cmd_ev) begin
            state_reg <= ST_REMOTE;
          end else if (start_req && start_ok) begin
            state_reg <= ST_TEST;
          end else if (manual_auto_key) begin
            state_reg <= ST_VIEW;
          end
        end
        ST_VIEW: begin
          if (cmd_ev) begin
            state_reg <= ST_REMOTE;
          end else if (stop_req) begin
            state_reg <= ST_READY;
          end
        end
      endcase
    end
  end

  assign remote_indicator = (state_reg == ST_REMOTE);
  assign keys_enabled     = (state_reg != ST_REMOTE);

  // result latches and interlock message
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pass_reg    <= 1'b0;
      fail_reg    <= 1'b0;
      ilk_msg_reg <= 1'b0;
    end else if (clk_en) begin
      if (state_reg == ST_TEST) begin
        if (test_done_fail) begin
          fail_reg <= 1'b1;
        end else if (test_done_pass) begin
          pass_reg <= 1'b1;
        end
      end else if ((state_reg == ST_READY) && start_req && start_ok) begin
        pass_reg <= 1'b0;
        fail_reg <= 1'b0;
      end
      if ((state_reg == ST_READY) && start_req && !start_ok) begin
        ilk_msg_reg <= 1'b1;
      end else if (stop_req || (start_req && start_ok)) begin
        ilk_msg_reg <= 1'b0;
      end
    end
  end

  assign test_out           = (state_reg == ST_TEST);
  assign pass_out           = pass_reg;
  assign fail_out           = fail_reg;
  assign interlock_open_msg = ilk_msg_reg;
  // command line completion pulse toward the command parser
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      line_done_reg <= 1'b0;
    end else if (clk_en) begin
      line_done_reg <= cmd_ev;
    end
  end
  assign cmd_line_done = line_done_reg;
  // write channel capture; address and data may arrive in either order
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      aw_addr_reg  <= '0;
      w_data_reg   <= '0;
      w_strb_reg   <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_held_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_held_reg <= 1'b1;
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (addr_mapped(aw_addr_reg, 1'b1) ||
                        (aw_addr_reg == REG_ID)) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration registers; gpib address above 30 is refused and kept
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg   <= CTRL_RESET;
      iface_reg  <= IFACE_RESET;
      serial_reg <= '0;
    end else if (clk_en && wr_fire) begin
      if (aw_addr_reg == REG_CTRL) begin
        ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg) & 32'h0000_0007;
      end
      if (aw_addr_reg == REG_IFACE) begin
        // address range check, unused interface code refused too
        if ((iface_wr[IF_ADDR_LSB +: 5] <= GPIB_ADDR_MAX) && !(&iface_wr[IF_SEL_LSB +: 2])) begin
          iface_reg <= iface_wr & 32'h0000_1f73;
        end
      end
      // serial number text shifts in one byte per write to the id register
      if (aw_addr_reg == REG_ID) begin
        serial_reg <= {serial_reg[SERIAL_LEN*8-9:0], w_data_reg[7:0]};
      end
    end
  end

  // read channel; one read outstanding, data registered
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= addr_mapped(s_axi_araddr, 1'b0) ? RESP_OKAY : RESP_SLVERR;
        unique case (s_axi_araddr)
          REG_CTRL:   s_axi_rdata <= ctrl_reg;
          REG_IFACE:  s_axi_rdata <= iface_reg;
          REG_STATUS: s_axi_rdata <= {24'h0, loop_closed, ilk_msg_reg,
                                      remote_indicator, 1'b0, state_reg};
          REG_RESULT: s_axi_rdata <= {29'h0, test_out, fail_reg, pass_reg};
          // id word xors model, serial tail with comma, and firmware
          REG_ID:     s_axi_rdata <= MODEL_CODE ^ {serial_reg[23:0], COMMA_CHAR} ^ FW_CODE;
          default:    s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// file: tss_props.sv
// port checks for the start/stop control block
// assumes one clock domain with the async active-low reset
`timescale 1ns/1ps
module tss_props
  import start_stop_pkg::*;
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        clk_en,
  input wire logic        stop_key,
  input wire logic        test_done_pass,
  input wire logic        test_done_fail,
  input wire logic        cmd_byte_valid,
  input wire logic [7:0]  cmd_byte,
  input wire logic        cmd_line_done,
  input wire logic        test_out,
  input wire logic        pass_out,
  input wire logic        fail_out,
  input wire logic        remote_indicator,
  input wire logic        keys_enabled,
  input wire logic        usb_active,
  input wire logic        serial_active,
  input wire logic        gpib_active,
  input wire logic [15:0] baud_div
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // end of a test, fail wins over pass
  sequence s_pass;
    test_out && clk_en && test_done_pass && !test_done_fail;
  endsequence
  sequence s_fail;
    test_out && clk_en && test_done_fail;
  endsequence
  a_pass_latch: assert property (s_pass |=> pass_out && !fail_out && !test_out)
    else $error("pass result not latched");
  a_fail_latch: assert property (s_fail |=> fail_out && !pass_out && !test_out)
    else $error("fail result not latched");
  a_stop_ends: assert property (test_out && clk_en && stop_key |=> !test_out)
    else $error("stop key left the test running");
  a_remote_exit: assert property (remote_indicator && clk_en && stop_key |=>
    !remote_indicator && keys_enabled) else $error("stop key kept remote state");
  a_keys_locked: assert property (remote_indicator == !keys_enabled)
    else $error("keys not locked in remote");
  a_one_iface: assert property ($onehot({usb_active, serial_active, gpib_active}))
    else $error("not exactly one interface active");
  a_usb_baud: assert property (usb_active |-> baud_div == BAUD_115200_DIV)
    else $error("usb channel not at fixed rate");
  a_lf_done: assert property (cmd_byte_valid && clk_en && cmd_byte == LINE_FEED
    && !gpib_active |=> cmd_line_done) else $error("line feed did not end a line");
endmodule

bind test_start_stop_control tss_props u_tss_props (
  .clk, .resetn, .clk_en, .stop_key, .test_done_pass, .test_done_fail, .cmd_byte_valid,
  .cmd_byte, .cmd_line_done, .test_out, .pass_out, .fail_out, .remote_indicator,
  .keys_enabled, .usb_active, .serial_active, .gpib_active, .baud_div);

// file: rear_fixture.sv
// model of the fixture closing rear contacts and the interlock loop
// assumes the bench calls its tasks; high means closed to common
`timescale 1ns/1ps
module rear_fixture (
  input wire logic clk,
  output logic     start_contact,
  output logic     stop_contact,
  output logic     loop_in_a,
  output logic     loop_in_b
);
  // open loop: one pin still driven, the other left low
  initial begin
    start_contact = 1'h0;
    stop_contact = 1'h0;
    loop_in_a = 1'h1;
    loop_in_b = 1'h0;
  end
  // closure held n cycles, then released
  task automatic close(input bit stp, input int n);
    @(posedge clk);
    if (stp) stop_contact <= 1'h1;
    else start_contact <= 1'h1;
    repeat (n) @(posedge clk);
    stop_contact <= 1'h0;
    start_contact <= 1'h0;
  endtask
  // loop stays as set until the bench changes it
  task automatic set_loop(input bit shut);
    @(posedge clk);
    loop_in_b <= shut;
  endtask
endmodule

// file: testbench.sv
// self-checking bench for the test start/stop control block
// assumes package, design, checker and fixture model compiled first
`timescale 1ns/1ps
module testbench;
  import start_stop_pkg::*;
  localparam logic [31:0] MC = 32'h0a5c_0003;  // arbitrary model code
  localparam logic [31:0] FC = 32'h0000_0102;  // arbitrary firmware code
  logic clk = 0, resetn = 0, clk_en = 1, start_key = 0, stop_key = 0, manual_auto_key = 0;
  logic remote_start = 0, test_done_pass = 0, test_done_fail = 0, cmd_byte_valid = 0;
  logic gpib_listen = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] cmd_byte = 0, s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [4:0] gpib_bus_addr = 0, ga;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic start_contact, stop_contact, loop_in_a, loop_in_b, test_out, fail_out, pass_out;
  logic cmd_line_done, remote_indicator, keys_enabled, interlock_open_msg, usb_active;
  logic serial_active, gpib_active, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [15:0] baud_div;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int errors = 0, compares = 0, ms = 1, i;       // ms: expected one-hot state
  bit mp, mf, mi, lp, ilk, gp;                   // expected flags
  int bd[5] = '{4166, 2083, 1041, 694, 347};     // cycles per bit by code

  // 40 MHz clock
  always #12.5 clk = ~clk;

  test_start_stop_control #(.MODEL_CODE(MC), .FW_CODE(FC)) u_test_start_stop_control (
    .clk, .resetn, .clk_en, .start_contact, .stop_contact, .loop_in_a, .loop_in_b,
    .test_out, .fail_out, .pass_out, .start_key, .stop_key, .manual_auto_key, .remote_start,
    .test_done_pass, .test_done_fail, .cmd_byte_valid, .cmd_byte, .gpib_listen,
    .gpib_bus_addr, .cmd_line_done, .remote_indicator, .keys_enabled, .interlock_open_msg,
    .usb_active, .serial_active, .gpib_active, .baud_div, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  rear_fixture u_fixture (.clk, .start_contact, .stop_contact, .loop_in_a, .loop_in_b);

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  // write: ready sampled mid-cycle, equal to its value at the next edge
  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic ah, wh, bh;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge clk);
      ah = s_axi_awready & s_axi_awvalid;
      wh = s_axi_wready & s_axi_wvalid;
      bh = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (ah) s_axi_awvalid <= 1'h0;
      if (wh) s_axi_wvalid <= 1'h0;
    end while (!bh);
    s_axi_bready <= 1'h0;
  endtask

  task automatic axr(input logic [7:0] a);
    logic ah, rh;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge clk);
      ah = s_axi_arready & s_axi_arvalid;
      rh = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ah) s_axi_arvalid <= 1'h0;
    end while (!rh);
    s_axi_rready <= 1'h0;
  endtask

  // reference model: 0 start, 1 stop, 2 mode key, 3 command, 4 ignored command, 5 pass, 6 fail
  task automatic step(input int e);
    case (e)
      0: if (ms == 2) begin
        if (ilk && !lp) mi = 1;
        else begin
          ms = 4;
          {mp, mf, mi} = 0;
        end
      end
      1: begin
        ms = 2;
        mi = 0;
      end
      2: if (ms == 2) ms = 1;
      // a command in view or ready goes remote
      3: if (ms < 3) ms = 8;
      4: ;
      5: begin
        ms = 2;
        mp = 1;
      end
      default: begin
        ms = 2;
        mf = 1;
      end
    endcase
  endtask

  task automatic cmp;
    @(negedge clk);
    chk("test_out", test_out, ms == 4);
    chk("pass_out", pass_out, mp);
    chk("fail_out", fail_out, mf);
    chk("remote", remote_indicator, ms == 8);
    chk("keys", keys_enabled, ms != 8);
    chk("ilk_msg", interlock_open_msg, mi);
    axr(REG_STATUS);
    chk("status", d, {24'h0, lp, mi, ms == 8, 1'h0, ms[3:0]});
    axr(REG_RESULT);
    chk("result", d, {29'h0, ms == 4, mf, mp});
  endtask

  task automatic ev(input int e);
    @(posedge clk);
    case (e)
      0: start_key <= 1'h1;
      1: stop_key <= 1'h1;
      2: manual_auto_key <= 1'h1;
      3, 4: begin
        cmd_byte_valid <= 1'h1;
        cmd_byte <= 8'($urandom_range(32, 126));
        @(posedge clk);
        cmd_byte <= LINE_FEED;
      end
      5: test_done_pass <= 1'h1;
      default: test_done_fail <= 1'h1;
    endcase
    @(posedge clk);
    {start_key, stop_key, manual_auto_key, test_done_pass, test_done_fail} <= '0;
    cmd_byte_valid <= 1'h0;
    clk_en <= 1'h1;
    if ((e == 3 || e == 4) && !gp) begin
      @(negedge clk);
      chk("line_done", cmd_line_done, e == 3);
    end
    step(e);
    cmp;
  endtask

  task automatic test_done;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // watchdog: two contact closures of 40010 cycles dominate the run
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    test_done;
  end

  initial begin
    void'($urandom(32'h91f5));
    repeat (10) @(posedge clk);
    resetn <= 1'h1;
    cmp;
    chk("serial", serial_active, 1);
    axr(REG_CTRL);
    chk("ctrl", d, CTRL_RESET);
    axr(REG_IFACE);
    chk("iface", d, IFACE_RESET);
    axr(8'h14);
    chk("unmapped", r, RESP_SLVERR);
    axw(REG_STATUS, 32'h0);
    chk("ro_write", r, RESP_SLVERR);
    for (i = 0; i < 5; i++) begin
      axw(REG_IFACE, 32'(i * 16 + 1));
      @(negedge clk);
      chk("baud_div", baud_div, bd[i]);
    end
    axw(REG_IFACE, 32'h0000_0000);
    @(negedge clk);
    chk("usb_baud", baud_div, bd[4]);
    chk("usb", usb_active, 1);
    ev(3);
    ev(1);
    ev(2);
    ga = 5'($urandom_range(0, 30));
    gp = 1;
    gpib_bus_addr <= ga;
    axw(REG_IFACE, {19'h0, ga, 8'h02});
    axw(REG_IFACE, 32'h0000_1f02);
    axr(REG_IFACE);
    chk("gpib_addr", d, {19'h0, ga, 8'h02});
    chk("gpib", gpib_active, 1);
    gpib_bus_addr <= ga + 5'h1;
    ev(4);
    gpib_bus_addr <= ga;
    gpib_listen <= 1'h0;
    ev(4);
    gpib_listen <= 1'h1;
    ev(3);
    gp = 0;
    ev(1);
    axw(REG_IFACE, IFACE_RESET);
    clk_en <= 1'h0;
    ev(4);
    ev(0);
    ev(5);
    ev(0);
    ev(6);
    ev(0);
    ev(1);
    for (i = 0; i < 3; i++) axw(REG_ID, 32'(8'h41 + i));
    axr(REG_ID);
    chk("id", d, MC ^ FC ^ 32'h4142_432c);
    ilk = 1;
    axw(REG_CTRL, 32'h0000_0004);
    ev(0);
    u_fixture.set_loop(1);
    lp = 1;
    ev(0);
    ev(1);
    ilk = 0;
    axw(REG_CTRL, 32'h0000_0000);
    u_fixture.set_loop(0);
    lp = 0;
    ev(0);
    ev(1);
    ilk = 1;
    lp = 1;
    u_fixture.set_loop(1);
    axw(REG_CTRL, 32'h0000_0006);
    u_fixture.close(0, 40010);
    step(0);
    cmp;
    u_fixture.close(1, 40010);
    step(1);
    cmp;
    test_done;
  end
endmodule
